// >>> flash_ctl_consts.svh
// Purpose: Constants for the flash array mode and access controller
// Assumes: Byte addresses into flash, 20-bit address space
// Notes: Times are in microseconds, cycle counts derived at 10 MHz
`ifndef FLASH_CTL_CONSTS_SVH
`define FLASH_CTL_CONSTS_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define USER_ARRAY_BYTES 20'hC0000
`define BOOT_ARRAY_BYTES 20'h02000
`define SMALL_REGION_END 20'h08000
`define MID_REGION_END 20'h10000
`define PROG_UNIT_MASK 20'h0007F
`define EMU_REGION_END 20'h08000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLOCK_MHZ 10
`define CHECK_TIME_US 1
`define CHECK_CYCLES (`CHECK_TIME_US * `CLOCK_MHZ)
`define ERASE_ALL_TIME_US 1000
`define ERASE_ALL_CYCLES (`ERASE_ALL_TIME_US * `CLOCK_MHZ)

`endif

// >>> flash_ctl_pkg.sv
// Purpose: Types for the flash array mode and access controller
// Assumes: Mode straps are decoded outside into mode_t
// Notes: States use Gray codes along the start-up path
package flash_ctl_pkg;

  typedef enum logic [2:0] {
    MODE_USER = 3'h0,
    MODE_USER_PROG = 3'h1,
    MODE_USER_BOOT = 3'h2,
    MODE_BOOT = 3'h3,
    MODE_PROGRAMMER = 3'h4
  } mode_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_EMBED_VEC = 3'h1,
    ST_CHECK = 3'h3,
    ST_ARRAY_VEC = 3'h2,
    ST_ERASE_ALL = 3'h7,
    ST_RUN = 3'h6
  } state_t;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_SERIAL = 2'h1,
    SRC_RAM = 2'h2,
    SRC_PROGRAMMER = 2'h3
  } source_t;

  typedef enum logic [1:0] {
    VEC_NONE = 2'h0,
    VEC_EMBEDDED = 2'h1,
    VEC_USER = 2'h2,
    VEC_BOOT = 2'h3
  } vector_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic erase;
    logic [19:0] addr;
  } req_t;

  typedef struct packed {
    logic hw_prot;
    logic sw_prot;
    logic err_prot;
  } prot_t;

endpackage

// >>> flash_region_decode.sv
// Purpose: Address checks for the selected memory array
// Assumes: Byte addresses
// Notes: Purely combinational
`include "flash_ctl_consts.svh"

module flash_region_decode (
  // Address and selection
  input wire logic [19:0] addr,
  input wire logic boot_sel,
  // Results
  output logic in_range,
  output logic unit_start,
  output logic [4:0] erase_block,
  output logic in_emu
);

  // ----------------------------------------
  // Erase block number: eight 4k, one 32k, eleven 64k
  // ----------------------------------------
  function automatic logic [4:0] block_of(input logic [19:0] a);
    if (a < `SMALL_REGION_END) begin
      block_of = {2'h0, a[14:12]};
    end else if (a < `MID_REGION_END) begin
      block_of = 5'h08;
    end else begin
      block_of = 5'(a[19:16]) + 5'h08;
    end
  endfunction

  wire logic [19:0] limit = boot_sel ? `BOOT_ARRAY_BYTES : `USER_ARRAY_BYTES;

  assign in_range = addr < limit;
  assign unit_start = (addr & `PROG_UNIT_MASK) == 20'h00000;
  assign erase_block = block_of(addr);
  assign in_emu = !boot_sel && (addr < `EMU_REGION_END);

endmodule

// >>> flash_mode_ctl.sv
// Purpose: Mode, array selection and access permission for the flash
// Assumes: Mode straps and requests are synchronous to clock
// Notes: Writes mean program a 128-byte unit, erase means erase a block
`include "flash_ctl_consts.svh"

// How it works
// - Two arrays: 768 kB user array and 8 kB user boot array.
// - Both arrays share a base; software flips array select before use.
// - Mode straps at reset choose the start array; switching stays possible.
// - Plain user mode reads flash but refuses program and erase.
// - Program/erase only in boot, user program, user boot, programmer modes.
// - Boot array modifiable only in boot and programmer modes.
// - The selected array is readable in every mode, except while program or erase is busy.
// - Reads beyond 8 kB of the boot array give undefined data.
// - User boot start: embedded vector, register check, then boot array vector.
// - Boot mode starts embedded and takes data over the serial channel.
// - Boot mode erases everything first; block erase only afterwards.
// - User program mode spans the routine; on completion back to user mode.
// - Software loads the routine into RAM before programming.
// - Any hardware, software or error protection blocks program and erase.
// - RAM can overlay the low part of the user array for emulation.
// - Programming goes in 128-byte units aligned to 0x00 or 0x80.
// - User array erases per block: 11x64k, 1x32k, 8x4k.
// - Arrays are unreadable while program or erase is busy.
module flash_mode_ctl #(
  parameter int ERASE_ALL_CYCLES = `ERASE_ALL_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Mode straps and software controls
  input wire flash_ctl_pkg::mode_t mode_pins,
  input wire logic array_select_wr,
  input wire logic array_select_val,
  input wire logic routine_loaded,
  input wire logic routine_start,
  input wire logic routine_done,
  input wire flash_ctl_pkg::prot_t prot,
  input wire logic emu_enable,
  // Access request
  input wire flash_ctl_pkg::req_t req,
  // Results
  output flash_ctl_pkg::mode_t mode,
  output logic array_select_register,
  output flash_ctl_pkg::vector_t vector_fetch,
  output flash_ctl_pkg::source_t data_source,
  output logic autobaud_en,
  output logic busy,
  output logic read_ok,
  output logic read_undef,
  output logic read_from_ram,
  output logic modify_ok,
  output logic refused,
  output logic [4:0] erase_block
);

  localparam logic [15:0] CHECK_CYCLES = 16'(`CHECK_CYCLES);
  localparam logic [19:0] ERASE_CYCLES = 20'(ERASE_ALL_CYCLES);

  flash_ctl_pkg::state_t state_ff, nxt_state;
  flash_ctl_pkg::mode_t mode_ff, nxt_mode, boot_mode_ff;
  logic sel_ff, nxt_sel;
  logic [19:0] cnt_ff, nxt_cnt;
  logic erased_ff, prog_ff, strap_ff;
  flash_ctl_pkg::vector_t vec_ff, nxt_vec;
  logic read_ok_ff, undef_ff, ram_ff, mod_ok_ff, refused_ff;
  logic [4:0] blk_ff;
  flash_ctl_pkg::source_t src_ff;
  logic baud_ff;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic in_range, unit_start, in_emu;
  logic [4:0] blk;

  flash_region_decode u_decode (
    .addr(req.addr),
    .boot_sel(sel_ff),
    .in_range(in_range),
    .unit_start(unit_start),
    .erase_block(blk),
    .in_emu(in_emu)
  );

  // ----------------------------------------
  // Permission
  // ----------------------------------------
  wire logic running = state_ff == flash_ctl_pkg::ST_RUN;
  wire logic is_boot = mode_ff == flash_ctl_pkg::MODE_BOOT;
  wire logic is_prgr = mode_ff == flash_ctl_pkg::MODE_PROGRAMMER;
  wire logic is_ubt = mode_ff == flash_ctl_pkg::MODE_USER_BOOT;
  wire logic is_uprog = mode_ff == flash_ctl_pkg::MODE_USER_PROG;
  wire logic mode_may_modify = is_boot || is_prgr || is_ubt || is_uprog;
  wire logic array_may_modify = !sel_ff || is_boot || is_prgr;
  wire logic any_prot = prot.hw_prot || prot.sw_prot || prot.err_prot;
  wire logic routine_ok = is_boot || is_prgr || routine_loaded;
  // Block erase waits for the automatic full erase in boot mode
  wire logic erase_ok = !is_boot || erased_ff;
  wire logic is_mod = req.valid && (req.write || req.erase);
  wire logic shape_ok = req.erase ? erase_ok : unit_start;
  wire logic grant_mod = is_mod && running && mode_may_modify && array_may_modify
                         && !any_prot && routine_ok && in_range && shape_ok;
  wire logic is_read = req.valid && !req.write && !req.erase;
  wire logic busy_now = (state_ff == flash_ctl_pkg::ST_ERASE_ALL) || prog_ff;
  // Reads are held off while a program or erase is in progress
  wire logic grant_read = is_read && running && !busy_now;

  // ----------------------------------------
  // Start-up sequence
  // ----------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_vec = vec_ff;
    nxt_mode = mode_ff;
    nxt_sel = sel_ff;
    case (state_ff)
      flash_ctl_pkg::ST_RESET: begin
        // Wait until the straps are caught, else the reset mode is lost
        if (strap_ff) begin
          nxt_mode = boot_mode_ff;
          nxt_sel = boot_mode_ff == flash_ctl_pkg::MODE_USER_BOOT;
          if (boot_mode_ff == flash_ctl_pkg::MODE_USER_BOOT
              || boot_mode_ff == flash_ctl_pkg::MODE_BOOT) begin
            nxt_state = flash_ctl_pkg::ST_EMBED_VEC;
            nxt_vec = flash_ctl_pkg::VEC_EMBEDDED;
          end else begin
            nxt_state = flash_ctl_pkg::ST_ARRAY_VEC;
            nxt_vec = flash_ctl_pkg::VEC_USER;
          end
        end
      end
      flash_ctl_pkg::ST_EMBED_VEC: begin
        nxt_state = flash_ctl_pkg::ST_CHECK;
        nxt_cnt = 20'h00000;
        nxt_vec = flash_ctl_pkg::VEC_NONE;
      end
      flash_ctl_pkg::ST_CHECK: begin
        nxt_cnt = cnt_ff + 20'h00001;
        if (cnt_ff >= 20'(CHECK_CYCLES) - 20'h00001) begin
          nxt_cnt = 20'h00000;
          if (is_boot) begin
            nxt_state = flash_ctl_pkg::ST_ERASE_ALL;
          end else begin
            nxt_state = flash_ctl_pkg::ST_ARRAY_VEC;
            nxt_vec = flash_ctl_pkg::VEC_BOOT;
          end
        end
      end
      flash_ctl_pkg::ST_ARRAY_VEC: begin
        nxt_state = flash_ctl_pkg::ST_RUN;
        nxt_vec = flash_ctl_pkg::VEC_NONE;
      end
      flash_ctl_pkg::ST_ERASE_ALL: begin
        nxt_cnt = cnt_ff + 20'h00001;
        if (cnt_ff >= ERASE_CYCLES - 20'h00001) begin
          nxt_state = flash_ctl_pkg::ST_RUN;
        end
      end
      flash_ctl_pkg::ST_RUN: begin
        // Software bank switch; user and user program modes swap with the routine, other modes change only through reset
        if (array_select_wr) begin
          nxt_sel = array_select_val;
        end
        if (mode_ff == flash_ctl_pkg::MODE_USER && routine_start) begin
          nxt_mode = flash_ctl_pkg::MODE_USER_PROG;
        end else if (is_uprog && routine_done) begin
          nxt_mode = flash_ctl_pkg::MODE_USER;
        end
      end
      default: begin
        nxt_state = flash_ctl_pkg::ST_RESET;
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= flash_ctl_pkg::ST_RESET;
      mode_ff <= flash_ctl_pkg::MODE_USER;
      sel_ff <= 1'b0;
      cnt_ff <= 20'h00000;
      vec_ff <= flash_ctl_pkg::VEC_NONE;
    end else begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      sel_ff <= nxt_sel;
      cnt_ff <= nxt_cnt;
      vec_ff <= nxt_vec;
    end
  end

  // Straps are caught on the first clock after reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_ff <= 1'b0;
      boot_mode_ff <= flash_ctl_pkg::MODE_USER;
    end else if (!strap_ff) begin
      strap_ff <= 1'b1;
      boot_mode_ff <= mode_pins;
    end
  end

  // Full erase done flag and one-cycle busy for each granted change
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      erased_ff <= 1'b0;
      prog_ff <= 1'b0;
    end else begin
      erased_ff <= erased_ff || (state_ff == flash_ctl_pkg::ST_ERASE_ALL
                                 && nxt_state == flash_ctl_pkg::ST_RUN);
      prog_ff <= grant_mod;
    end
  end

  // ----------------------------------------
  // Registered answers
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      read_ok_ff <= 1'b0;
      undef_ff <= 1'b0;
      ram_ff <= 1'b0;
      mod_ok_ff <= 1'b0;
      refused_ff <= 1'b0;
      blk_ff <= 5'h00;
    end else begin
      read_ok_ff <= grant_read;
      undef_ff <= grant_read && !in_range;
      ram_ff <= grant_read && emu_enable && in_emu && !is_boot && !is_prgr;
      mod_ok_ff <= grant_mod;
      refused_ff <= (is_mod && !grant_mod) || (is_read && !grant_read);
      blk_ff <= blk;
    end
  end

  assign mode = mode_ff;
  assign array_select_register = sel_ff;
  assign vector_fetch = vec_ff;
  assign data_source = src_ff;
  assign autobaud_en = baud_ff;
  assign busy = prog_ff;
  assign read_ok = read_ok_ff;
  assign read_undef = undef_ff;
  assign read_from_ram = ram_ff;
  assign modify_ok = mod_ok_ff;
  assign refused = refused_ff;
  assign erase_block = blk_ff;

  // Data source follows the mode; serial rate tracking only in boot mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      src_ff <= flash_ctl_pkg::SRC_NONE;
      baud_ff <= 1'b0;
    end else begin
      src_ff <= is_boot ? flash_ctl_pkg::SRC_SERIAL :
                is_prgr ? flash_ctl_pkg::SRC_PROGRAMMER :
                (is_ubt || is_uprog) ? flash_ctl_pkg::SRC_RAM : flash_ctl_pkg::SRC_NONE;
      baud_ff <= is_boot && running;
    end
  end

endmodule

// >>> flash_mode_ctl_properties.sv
// Purpose: Concurrent checks on the flash mode controller ports
// Assumes: Answers are registered one cycle after the request edge
// Notes: Bound onto every flash_mode_ctl instance
module flash_mode_ctl_checker #(
  parameter int ERASE_ALL_CYCLES = 10000
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Requests
  input wire flash_ctl_pkg::req_t req,
  input wire flash_ctl_pkg::prot_t prot,
  // Results
  input wire flash_ctl_pkg::mode_t mode,
  input wire logic array_select_register,
  input wire flash_ctl_pkg::vector_t vector_fetch,
  input wire logic busy,
  input wire logic read_ok,
  input wire logic read_undef,
  input wire logic modify_ok,
  input wire logic refused,
  input wire logic [4:0] erase_block
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic modreq;
  logic rdreq;
  logic [4:0] blk_of;
  assign modreq = req.valid && (req.write || req.erase);
  assign rdreq = req.valid && !req.write && !req.erase;
  // Above 0x10000 each 64k block, then one 32k block, then 4k blocks
  assign blk_of = (req.addr >= 20'h10000) ? 5'(req.addr[19:16]) + 5'h08 :
                  (req.addr >= 20'h08000) ? 5'h08 : {2'h0, req.addr[14:12]};
  sequence embedded_vec;
    vector_fetch == flash_ctl_pkg::VEC_EMBEDDED && mode == flash_ctl_pkg::MODE_USER_BOOT;
  endsequence
  sequence boot_vec_after_check;
    ##[8:14] vector_fetch == flash_ctl_pkg::VEC_BOOT;
  endsequence
  user_no_modify_a: assert property (modify_ok |-> $past(mode) != flash_ctl_pkg::MODE_USER)
    else $error("modify granted in user mode");
  boot_array_guard_a: assert property (modify_ok && $past(array_select_register) |->
    $past(mode) inside {flash_ctl_pkg::MODE_BOOT, flash_ctl_pkg::MODE_PROGRAMMER})
    else $error("boot array modified in wrong mode");
  unit_align_a: assert property ($past(modreq && req.write && req.addr[6:0] != 7'h00) |-> !modify_ok)
    else $error("unaligned program granted");
  prot_blocks_a: assert property ($past(modreq && (prot != 3'h0)) |-> refused && !modify_ok)
    else $error("modify granted under protection");
  busy_on_grant_a: assert property (modify_ok |-> busy)
    else $error("grant without busy");
  read_while_busy_a: assert property ($past(busy && rdreq) |-> !read_ok && refused)
    else $error("read granted while busy");
  undef_read_a: assert property ($past(rdreq && array_select_register && req.addr >= 20'h02000)
    && read_ok |-> read_undef) else $error("read past boot array not flagged");
  boot_start_a: assert property (embedded_vec |-> boot_vec_after_check)
    else $error("boot array vector missing after check");
  erase_block_map_a: assert property ($past(arst_n) |-> erase_block == $past(blk_of))
    else $error("wrong erase block");
endmodule

bind flash_mode_ctl flash_mode_ctl_checker #(.ERASE_ALL_CYCLES(ERASE_ALL_CYCLES)) checker_inst (
  .clock(clock), .arst_n(arst_n), .req(req), .prot(prot), .mode(mode),
  .array_select_register(array_select_register), .vector_fetch(vector_fetch), .busy(busy),
  .read_ok(read_ok), .read_undef(read_undef), .modify_ok(modify_ok), .refused(refused),
  .erase_block(erase_block));

// >>> routine_host_model.sv
// Purpose: Software side that downloads and runs the program/erase routine
// Assumes: go is a one-cycle pulse from the bench
// Notes: Routine length set by DONE_CYCLES, prompt or slow
module routine_host_model #(
  parameter logic [3:0] DONE_CYCLES = 4'h6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Bench commands
  input wire logic resident,
  input wire logic go,
  // Toward the controller
  output logic routine_loaded,
  output logic routine_start,
  output logic routine_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      routine_loaded <= 1'b0;
      routine_start <= 1'b0;
      routine_done <= 1'b0;
      left_ff <= 4'h0;
    end else begin
      routine_loaded <= resident;
      // Only starts a routine that is already resident and not running
      routine_start <= go && routine_loaded && (left_ff == 4'h0);
      routine_done <= (left_ff == 4'h1);
      if (routine_start) begin
        left_ff <= DONE_CYCLES;
      end else if (left_ff != 4'h0) begin
        left_ff <= left_ff - 4'h1;
      end
    end
  end
endmodule

// >>> test_flash_mode_ctl.sv
// Purpose: Self-checking bench for the flash mode controller
// Assumes: Full erase shortened to 20 cycles
// Notes: Each row restarts the device when its strap mode differs
module test_flash_mode_ctl;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
  typedef struct packed {
    logic [2:0] m;
    logic sel;
    logic [1:0] op;
    logic [19:0] a;
    logic [2:0] p;
    logic [1:0] ctl;
    logic [4:0] exp;
    logic [4:0] blk;
  } row_t;
  logic clock, arst_n, array_select_wr, array_select_val, resident, go, emu_enable;
  logic routine_loaded, routine_start, routine_done, array_select_register, autobaud_en;
  logic busy, read_ok, read_undef, read_from_ram, modify_ok, refused;
  logic [4:0] erase_block;
  flash_ctl_pkg::mode_t mode_pins, mode;
  flash_ctl_pkg::prot_t prot;
  flash_ctl_pkg::req_t req;
  flash_ctl_pkg::vector_t vector_fetch;
  flash_ctl_pkg::source_t data_source;
  int num_errors = 0;
  int n_compared = 0;
  // Expected {read_ok, read_undef, read_from_ram, modify_ok, refused}; ctl is {resident, emu}
  row_t rows [16] = '{
    '{3'h0, 1'h0, 2'h0, 20'h00100, 3'h0, 2'h0, 5'h10, 5'h00},
    '{3'h0, 1'h0, 2'h2, 20'h00080, 3'h0, 2'h0, 5'h01, 5'h00},
    '{3'h1, 1'h0, 2'h2, 20'h00100, 3'h0, 2'h2, 5'h02, 5'h00},
    '{3'h2, 1'h0, 2'h2, 20'h00080, 3'h0, 2'h2, 5'h02, 5'h00},
    '{3'h2, 1'h1, 2'h2, 20'h00080, 3'h0, 2'h2, 5'h01, 5'h00},
    '{3'h2, 1'h1, 2'h0, 20'h03000, 3'h0, 2'h2, 5'h18, 5'h03},
    '{3'h2, 1'h0, 2'h0, 20'h01000, 3'h0, 2'h3, 5'h14, 5'h01},
    '{3'h2, 1'h0, 2'h2, 20'h00081, 3'h0, 2'h2, 5'h01, 5'h00},
    '{3'h2, 1'h0, 2'h2, 20'h00080, 3'h4, 2'h2, 5'h01, 5'h00},
    '{3'h2, 1'h0, 2'h1, 20'h08000, 3'h1, 2'h2, 5'h01, 5'h08},
    '{3'h2, 1'h0, 2'h2, 20'h00080, 3'h0, 2'h0, 5'h01, 5'h00},
    '{3'h2, 1'h0, 2'h1, 20'hB0000, 3'h0, 2'h2, 5'h02, 5'h13},
    '{3'h3, 1'h1, 2'h2, 20'h00080, 3'h0, 2'h0, 5'h02, 5'h00},
    '{3'h3, 1'h0, 2'h1, 20'h07000, 3'h2, 2'h0, 5'h01, 5'h07},
    '{3'h3, 1'h0, 2'h1, 20'h08000, 3'h0, 2'h0, 5'h02, 5'h08},
    '{3'h4, 1'h1, 2'h1, 20'h00000, 3'h0, 2'h0, 5'h02, 5'h00}};
  flash_mode_ctl #(.ERASE_ALL_CYCLES(20)) flash_mode_ctl_inst (
    .clock(clock), .arst_n(arst_n), .mode_pins(mode_pins), .array_select_wr(array_select_wr),
    .array_select_val(array_select_val), .routine_loaded(routine_loaded),
    .routine_start(routine_start), .routine_done(routine_done), .prot(prot),
    .emu_enable(emu_enable), .req(req), .mode(mode), .array_select_register(array_select_register),
    .vector_fetch(vector_fetch), .data_source(data_source), .autobaud_en(autobaud_en),
    .busy(busy), .read_ok(read_ok), .read_undef(read_undef), .read_from_ram(read_from_ram),
    .modify_ok(modify_ok), .refused(refused), .erase_block(erase_block));
  routine_host_model routine_host_model_inst (
    .clock(clock), .arst_n(arst_n), .resident(resident), .go(go),
    .routine_loaded(routine_loaded), .routine_start(routine_start), .routine_done(routine_done));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic print_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Strap change plus reset is the only way into or out of boot, user boot and programmer modes
  task automatic restart(input logic [2:0] m);
    flash_ctl_pkg::source_t src_exp;
    src_exp = (m == 3'h3) ? flash_ctl_pkg::SRC_SERIAL : (m == 3'h4) ? flash_ctl_pkg::SRC_PROGRAMMER :
              (m != 3'h0) ? flash_ctl_pkg::SRC_RAM : flash_ctl_pkg::SRC_NONE;
    arst_n <= 1'b0;
    mode_pins <= flash_ctl_pkg::mode_t'(m);
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    repeat (50) @(posedge clock);
    #1;
    `CHK(array_select_register, m == 3'h2)
    `CHK(mode, m)
    `CHK(data_source, src_exp)
    `CHK({autobaud_en, data_source == flash_ctl_pkg::SRC_SERIAL}, {2{m == 3'h3}})
    @(posedge clock);
  endtask
  task automatic access(input row_t r);
    array_select_wr <= 1'b1;
    array_select_val <= r.sel;
    prot <= r.p;
    @(posedge clock);
    array_select_wr <= 1'b0;
    req <= '{1'b1, r.op[1], r.op[0], r.a};
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    `CHK({read_ok, read_undef, read_from_ram, modify_ok, refused}, r.exp)
    `CHK(erase_block, r.blk)
    @(posedge clock);
  endtask
  initial begin
    {arst_n, array_select_wr, array_select_val, resident, go, emu_enable} = 6'h00;
    mode_pins = flash_ctl_pkg::MODE_USER;
    prot = 3'h0;
    req = '0;
    foreach (rows[i]) begin
      resident <= rows[i].ctl[1];
      emu_enable <= rows[i].ctl[0];
      if (i == 0 || rows[i].m != rows[i - 1].m) restart(rows[i].m);
      access(rows[i]);
    end
    // Read straight after a granted program is turned away
    req <= '{1'b1, 1'b1, 1'b0, 20'h00100};
    @(posedge clock);
    req <= '{1'b1, 1'b0, 1'b0, 20'h00100};
    #1;
    `CHK({modify_ok, busy}, 2'h3)
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    `CHK({read_ok, refused}, 2'h1)
    @(posedge clock);
    resident <= 1'b1;
    restart(3'h0);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `CHK(mode, flash_ctl_pkg::MODE_USER_PROG)
    repeat (8) @(posedge clock);
    #1;
    `CHK(mode, flash_ctl_pkg::MODE_USER)
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    print_verdict();
  end
endmodule
